// >>> core/prc_pkg.sv
package prc_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned PRC_CLK_KHZ      = 50_000;
  localparam int unsigned PRC_ACK_TMO_MS   = 4000;
  localparam int unsigned PRC_ENTRY_TMO_MS = 4000;
  localparam int unsigned PRC_PBO_HOLD_MS  = 4000;
  localparam int unsigned PRC_TMR_W        = 28;
  localparam logic [PRC_TMR_W-1:0] PRC_ACK_TMO_CYCLES   = PRC_TMR_W'(PRC_ACK_TMO_MS * PRC_CLK_KHZ);
  localparam logic [PRC_TMR_W-1:0] PRC_ENTRY_TMO_CYCLES = PRC_TMR_W'(PRC_ENTRY_TMO_MS * PRC_CLK_KHZ);
  localparam logic [PRC_TMR_W-1:0] PRC_PBO_HOLD_CYCLES  = PRC_TMR_W'(PRC_PBO_HOLD_MS * PRC_CLK_KHZ);
  localparam logic [PRC_TMR_W-1:0] PRC_TMR_ZERO         = 28'h0000000;
  localparam logic [PRC_TMR_W-1:0] PRC_TMR_ONE          = 28'h0000001;

  // ==========================================================
  // Input vector layout
  // ==========================================================
  localparam int unsigned PRC_IN_W          = 19;
  localparam int unsigned PRC_I_CPU_SHUT    = 0;
  localparam int unsigned PRC_I_MC_HR       = 1;
  localparam int unsigned PRC_I_MC_HR_PC    = 2;
  localparam int unsigned PRC_I_MC_HR_PD    = 3;
  localparam int unsigned PRC_I_MC_PBO      = 4;
  localparam int unsigned PRC_I_MC_WDT      = 5;
  localparam int unsigned PRC_I_MC_HWERR    = 6;
  localparam int unsigned PRC_I_MC_GLOBAL   = 7;
  localparam int unsigned PRC_I_PWRGD_STUCK = 8;
  localparam int unsigned PRC_I_PM_WDT      = 9;
  localparam int unsigned PRC_I_ACK         = 10;
  localparam int unsigned PRC_I_WAKE        = 11;
  localparam int unsigned PRC_I_SEQ_DONE    = 12;
  localparam int unsigned PRC_I_PBO_LEVEL   = 13;
  localparam int unsigned PRC_I_GLB_BIT     = 14;
  localparam int unsigned PRC_I_PC_BIT      = 15;
  localparam int unsigned PRC_I_SLEEP       = 16;
  localparam int unsigned PRC_I_DS_EN       = 17;
  localparam int unsigned PRC_I_DS_OK       = 18;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [2:0] {
    PRC_ST_IDLE  = 3'h0,
    PRC_ST_WARN  = 3'h1,
    PRC_ST_RESET = 3'h3,
    PRC_ST_HOLD  = 3'h2,
    PRC_ST_S5    = 3'h6
  } prc_state_t;

  typedef enum logic [2:0] {
    PRC_OC_NONE    = 3'h0,
    PRC_OC_HOST    = 3'h1,
    PRC_OC_HOST_PC = 3'h2,
    PRC_OC_GLOBAL  = 3'h3,
    PRC_OC_S5      = 3'h4
  } prc_outcome_t;

endpackage : prc_pkg

// >>> core/prc_sync.sv
`timescale 1ns/1ps
module prc_sync
  import prc_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire  [W-1:0] agree = ~(s2 ^ s3);
  // Take a new level only once the last two stages agree
  wire  [W-1:0] next_dout = (agree & s2) | (~agree & dout);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      dout <= '0;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= next_dout;
    end
  end

endmodule // prc_sync

// >>> core/prc_decoder.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Long power button override goes straight S5
// - Shutdown cycle with global bit gives global
// - Shutdown, global clear, cycle bit: host power-cycle
// - Shutdown, both bits clear: plain host reset
// - Controller host reset follows requested variant
// - Controller override, watchdog, error go S5
// - Controller global or power-good stuck: global
// - Power-down host reset: cycle, hold until wake
// - Unfinished reset sequence times out to global
// - Power watchdog expiry goes straight S5
// - Plain host reset dropped while sleeping
// - Power-cycle reset in sleep skips warning
// - Global reset sends no warning, immediate
// - Unacknowledged warning escalates to global reset
// - S5 continues into deep sleep when allowed
// - Warn processor, await acknowledge, then reset
// - Acknowledge timeout proceeds to global reset
module prc_decoder
  import prc_pkg::*;
#(
  parameter logic [PRC_TMR_W-1:0] ACK_TMO_CYCLES   = PRC_ACK_TMO_CYCLES,
  parameter logic [PRC_TMR_W-1:0] ENTRY_TMO_CYCLES = PRC_ENTRY_TMO_CYCLES,
  parameter logic [PRC_TMR_W-1:0] PBO_HOLD_CYCLES  = PRC_PBO_HOLD_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       cpu_shutdown,
  input  wire logic       mc_host_reset,
  input  wire logic       mc_host_reset_pc,
  input  wire logic       mc_host_reset_pd,
  input  wire logic       mc_pwrbtn_override,
  input  wire logic       mc_watchdog,
  input  wire logic       mc_hw_error,
  input  wire logic       mc_global_reset,
  input  wire logic       processor_power_good_stuck,
  input  wire logic       pm_watchdog,
  input  wire logic       reset_ack,
  input  wire logic       wake_event,
  input  wire logic       reset_seq_done,
  input  wire logic       pwrbtn_override,
  input  wire logic       global_reset_bit,
  input  wire logic       power_cycle_bit,
  input  wire logic       sleep_state,
  input  wire logic       deep_sleep_enable,
  input  wire logic       deep_sleep_ready,
  output logic            platform_reset_out_n,
  output logic            reset_warn,
  output logic            power_cycle,
  output logic            global_reset,
  output logic            s5_entry,
  output logic            deep_sleep_state,
  output logic            host_hold,
  output logic            ack_timeout,
  output logic            entry_timeout,
  output logic [2:0]      outcome
);

  // ==========================================================
  // Input conditioning
  // ==========================================================
  wire  [PRC_IN_W-1:0] raw = {deep_sleep_ready, deep_sleep_enable, sleep_state, power_cycle_bit,
                              global_reset_bit, pwrbtn_override, reset_seq_done, wake_event, reset_ack,
                              pm_watchdog, processor_power_good_stuck, mc_global_reset, mc_hw_error,
                              mc_watchdog, mc_pwrbtn_override, mc_host_reset_pd, mc_host_reset_pc,
                              mc_host_reset, cpu_shutdown};
  logic [PRC_IN_W-1:0] lvl;
  logic [PRC_IN_W-1:0] lvl_d;
  wire  [PRC_IN_W-1:0] rise = lvl & ~lvl_d;

  prc_sync #(.W(PRC_IN_W)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .din    (raw),
    .dout   (lvl)
  );

  // ==========================================================
  // Long-press detector
  // ==========================================================
  logic [PRC_TMR_W-1:0] pbo_cnt;
  wire                  pbo_held  = lvl[PRC_I_PBO_LEVEL];
  wire                  pbo_sat   = (pbo_cnt == PBO_HOLD_CYCLES);
  wire                  pbo_long  = pbo_held && (pbo_cnt == PBO_HOLD_CYCLES - PRC_TMR_ONE);
  wire [PRC_TMR_W-1:0]  next_pbo  = !pbo_held ? PRC_TMR_ZERO : (pbo_sat ? pbo_cnt : pbo_cnt + PRC_TMR_ONE);

  // ==========================================================
  // Trigger classification
  // ==========================================================
  function automatic prc_outcome_t prc_classify(input logic [PRC_IN_W-1:0] ev,
                                                input logic [PRC_IN_W-1:0] lv,
                                                input logic                long_press);
    logic s5;
    logic glb;
    logic hpc;
    logic hst;
    s5  = long_press || ev[PRC_I_MC_PBO] || ev[PRC_I_MC_WDT] || ev[PRC_I_MC_HWERR] || ev[PRC_I_PM_WDT];
    glb = (ev[PRC_I_CPU_SHUT] && lv[PRC_I_GLB_BIT]) || ev[PRC_I_MC_GLOBAL] || ev[PRC_I_PWRGD_STUCK];
    hpc = (ev[PRC_I_CPU_SHUT] && !lv[PRC_I_GLB_BIT] && lv[PRC_I_PC_BIT]) || ev[PRC_I_MC_HR_PC] ||
          ev[PRC_I_MC_HR_PD];
    hst = (ev[PRC_I_CPU_SHUT] && !lv[PRC_I_GLB_BIT] && !lv[PRC_I_PC_BIT]) || ev[PRC_I_MC_HR];
    if (s5) begin
      prc_classify = PRC_OC_S5;
    end else if (glb) begin
      prc_classify = PRC_OC_GLOBAL;
    end else if (hpc) begin
      prc_classify = PRC_OC_HOST_PC;
    end else if (hst && !lv[PRC_I_SLEEP]) begin
      prc_classify = PRC_OC_HOST;
    end else begin
      prc_classify = PRC_OC_NONE;
    end
  endfunction

  wire prc_outcome_t req       = prc_classify(rise, lvl, pbo_long);
  wire               req_top   = (req == PRC_OC_S5) || (req == PRC_OC_GLOBAL);
  wire               req_pd    = rise[PRC_I_MC_HR_PD] && (req == PRC_OC_HOST_PC);
  wire               ack_ev    = rise[PRC_I_ACK];
  wire               wake_ev   = rise[PRC_I_WAKE];
  wire               done_ev   = rise[PRC_I_SEQ_DONE];

  // ==========================================================
  // Sequencer
  // ==========================================================
  prc_state_t           state;
  prc_state_t           next_state;
  prc_outcome_t         kind;
  prc_outcome_t         next_kind;
  logic                 pd;
  logic                 next_pd;
  logic [PRC_TMR_W-1:0] timer;
  logic                 next_ack_tmo;
  logic                 next_entry_tmo;

  wire ack_expired   = (timer >= ACK_TMO_CYCLES - PRC_TMR_ONE);
  wire entry_expired = (timer >= ENTRY_TMO_CYCLES - PRC_TMR_ONE);

  always_comb begin
    next_state     = state;
    next_kind      = kind;
    next_pd        = pd;
    next_ack_tmo   = 1'b0;
    next_entry_tmo = 1'b0;
    case (state)
      PRC_ST_IDLE, PRC_ST_WARN: begin
        if (req == PRC_OC_S5) begin
          next_state = PRC_ST_S5;
          next_kind  = PRC_OC_S5;
        end else if (req == PRC_OC_GLOBAL) begin
          next_state = PRC_ST_RESET;
          next_kind  = PRC_OC_GLOBAL;
        end else if (state == PRC_ST_IDLE && req != PRC_OC_NONE) begin
          next_kind  = req;
          next_pd    = req_pd;
          next_state = (req == PRC_OC_HOST_PC && lvl[PRC_I_SLEEP]) ? PRC_ST_RESET : PRC_ST_WARN;
        end else if (state == PRC_ST_WARN && ack_ev) begin
          next_state = PRC_ST_RESET;
        end else if (state == PRC_ST_WARN && ack_expired) begin
          next_state   = PRC_ST_RESET;
          next_kind    = PRC_OC_GLOBAL;
          next_ack_tmo = 1'b1;
        end
      end
      PRC_ST_RESET: begin
        if (req == PRC_OC_S5) begin
          next_state = PRC_ST_S5;
          next_kind  = PRC_OC_S5;
        end else if (done_ev) begin
          next_state = (pd && kind == PRC_OC_HOST_PC) ? PRC_ST_HOLD : PRC_ST_IDLE;
          next_kind  = (pd && kind == PRC_OC_HOST_PC) ? kind : PRC_OC_NONE;
        end else if (entry_expired && kind != PRC_OC_GLOBAL) begin
          next_kind      = PRC_OC_GLOBAL;
          next_entry_tmo = 1'b1;
        end
      end
      PRC_ST_HOLD: begin
        if (req == PRC_OC_S5) begin
          next_state = PRC_ST_S5;
          next_kind  = PRC_OC_S5;
        end else if (wake_ev) begin
          next_state = PRC_ST_IDLE;
          next_kind  = PRC_OC_NONE;
        end
      end
      PRC_ST_S5: begin
        // S5 ignores everything but a wake
        if (wake_ev) begin
          next_state = PRC_ST_IDLE;
          next_kind  = PRC_OC_NONE;
        end
      end
      default: begin
        next_state = PRC_ST_IDLE;
        next_kind  = PRC_OC_NONE;
      end
    endcase
    if (next_state == PRC_ST_IDLE) begin
      next_pd = 1'b0;
    end
  end

  // Timer restarts on any state or kind change, saturates otherwise
  wire restart = (next_state != state) || (next_kind != kind);
  wire [PRC_TMR_W-1:0] next_timer = restart ? PRC_TMR_ZERO :
                                    (&timer ? timer : timer + PRC_TMR_ONE);

  // ==========================================================
  // Output decode
  // ==========================================================
  wire next_in_reset = (next_state == PRC_ST_RESET);
  wire next_plt_n    = !(next_in_reset || next_state == PRC_ST_HOLD || next_state == PRC_ST_S5);
  wire next_cycle    = next_in_reset && (next_kind == PRC_OC_HOST_PC || next_kind == PRC_OC_GLOBAL);
  wire next_global   = next_in_reset && (next_kind == PRC_OC_GLOBAL);
  wire next_s5       = (next_state == PRC_ST_S5);
  wire next_deep     = next_s5 && lvl[PRC_I_DS_EN] && lvl[PRC_I_DS_OK];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lvl_d   <= '0;
      pbo_cnt <= PRC_TMR_ZERO;
      state   <= PRC_ST_IDLE;
      kind    <= PRC_OC_NONE;
      pd      <= 1'b0;
      timer   <= PRC_TMR_ZERO;
    end else begin
      lvl_d   <= lvl;
      pbo_cnt <= next_pbo;
      state   <= next_state;
      kind    <= next_kind;
      pd      <= next_pd;
      timer   <= next_timer;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      platform_reset_out_n <= 1'b0;
      reset_warn           <= 1'b0;
      power_cycle          <= 1'b0;
      global_reset         <= 1'b0;
      s5_entry             <= 1'b0;
      deep_sleep_state     <= 1'b0;
      host_hold            <= 1'b0;
      ack_timeout          <= 1'b0;
      entry_timeout        <= 1'b0;
      outcome              <= PRC_OC_NONE;
    end else begin
      platform_reset_out_n <= next_plt_n;
      reset_warn           <= (next_state == PRC_ST_WARN);
      power_cycle          <= next_cycle;
      global_reset         <= next_global;
      s5_entry             <= next_s5;
      deep_sleep_state     <= next_deep;
      host_hold            <= (next_state == PRC_ST_HOLD);
      ack_timeout          <= next_ack_tmo;
      entry_timeout        <= next_entry_tmo;
      outcome              <= next_kind;
    end
  end

endmodule // prc_decoder

// >>> bench/prc_decoder_checker.sv
`timescale 1ns/1ps
module prc_decoder_checker
  import prc_pkg::*;
#(
  parameter logic [PRC_TMR_W-1:0] ACK_TMO_CYCLES = PRC_ACK_TMO_CYCLES
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       platform_reset_out_n,
  input wire logic       reset_warn,
  input wire logic       power_cycle,
  input wire logic       global_reset,
  input wire logic       s5_entry,
  input wire logic       deep_sleep_state,
  input wire logic       host_hold,
  input wire logic       ack_timeout,
  input wire logic       entry_timeout,
  input wire logic [2:0] outcome
);
  // ==========================================================
  // Warning length counter
  // ==========================================================
  logic [PRC_TMR_W-1:0] warn_len;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      warn_len <= PRC_TMR_ZERO;
    end else begin
      warn_len <= reset_warn ? warn_len + PRC_TMR_ONE : PRC_TMR_ZERO;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // Properties
  // ==========================================================
  glob_kind_a: assert property (global_reset |-> power_cycle && !platform_reset_out_n && !reset_warn && outcome == 3'h3)
    else $error("global kind outputs disagree");
  s5_kind_a: assert property (s5_entry |-> !platform_reset_out_n && outcome == 3'h4 && !reset_warn && !global_reset)
    else $error("s5 outputs disagree");
  deep_sleep_a: assert property (deep_sleep_state |-> s5_entry)
    else $error("deep sleep outside s5");
  ack_esc_a: assert property (ack_timeout |-> global_reset && !reset_warn && $past(reset_warn))
    else $error("ack timeout without escalation");
  warn_bound_a: assert property (warn_len <= ACK_TMO_CYCLES)
    else $error("warning outstanding too long");
  entry_esc_a: assert property (entry_timeout |-> global_reset && !$past(global_reset) && !$past(platform_reset_out_n))
    else $error("entry timeout without escalation");
  warn_kind_a: assert property (reset_warn |-> platform_reset_out_n && outcome inside {3'h1, 3'h2} && !power_cycle)
    else $error("warning with wrong kind");
  warn_end_a: assert property ($fell(reset_warn) |-> !platform_reset_out_n)
    else $error("warning ended without reset");
  hold_off_a: assert property (host_hold |-> !platform_reset_out_n && !reset_warn && !s5_entry)
    else $error("hold state outputs disagree");

  cover property (ack_timeout);
  cover property (entry_timeout);
  cover property (host_hold);
  cover property (deep_sleep_state);
endmodule // prc_decoder_checker

bind prc_decoder prc_decoder_checker #(.ACK_TMO_CYCLES(ACK_TMO_CYCLES)) u_checker (
  .clk(clk), .resetn(resetn), .platform_reset_out_n(platform_reset_out_n), .reset_warn(reset_warn),
  .power_cycle(power_cycle), .global_reset(global_reset), .s5_entry(s5_entry), .deep_sleep_state(deep_sleep_state),
  .host_hold(host_hold), .ack_timeout(ack_timeout), .entry_timeout(entry_timeout), .outcome(outcome));

// >>> bench/prc_cpu_model.sv
`timescale 1ns/1ps
module prc_cpu_model
  import prc_pkg::*;
#(
  parameter int ACK_DLY  = 8,
  parameter int DONE_DLY = 10
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic reset_warn,
  input  wire logic platform_reset_out_n,
  input  wire logic ack_en,
  input  wire logic done_en,
  output logic      reset_ack,
  output logic      reset_seq_done
);
  // ==========================================================
  // Processor side of the warning handshake
  // ==========================================================
  logic [15:0] warn_cnt;
  logic [15:0] reset_control_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      warn_cnt       <= 16'h0;
      reset_control_reg        <= 16'h0;
      reset_ack      <= 1'b0;
      reset_seq_done <= 1'b0;
    end else begin
      warn_cnt <= reset_warn ? warn_cnt + 16'h1 : 16'h0;
      reset_control_reg  <= platform_reset_out_n ? 16'h0 : reset_control_reg + 16'h1;
      reset_ack      <= reset_warn && ack_en && warn_cnt >= 16'(ACK_DLY);
      // Held until reset releases, so it is never mistaken for a second event
      reset_seq_done <= !platform_reset_out_n && done_en && reset_control_reg >= 16'(DONE_DLY);
    end
  end
endmodule // prc_cpu_model

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench
  import prc_pkg::*;
;
  localparam logic [PRC_TMR_W-1:0] ACK = 28'h0000028;
  localparam logic [PRC_TMR_W-1:0] ENT = 28'h000003c;
  localparam logic [PRC_TMR_W-1:0] PBO = 28'h000001e;
  logic       clk, resetn, pbo, glb, pcb, slp, ds_en, ds_ok, ack_en, done_en;
  logic [12:0] ev;
  wire logic  reset_ack, reset_seq_done, platform_reset_out_n, reset_warn, power_cycle, global_reset;
  wire logic  s5_entry, deep_sleep_state, host_hold, ack_timeout, entry_timeout;
  wire logic [2:0] outcome;
  int         err_count, checks, cycles, n;

  prc_decoder #(.ACK_TMO_CYCLES(ACK), .ENTRY_TMO_CYCLES(ENT), .PBO_HOLD_CYCLES(PBO)) u_dut (
    .clk(clk), .resetn(resetn), .cpu_shutdown(ev[0]), .mc_host_reset(ev[1]), .mc_host_reset_pc(ev[2]),
    .mc_host_reset_pd(ev[3]), .mc_pwrbtn_override(ev[4]), .mc_watchdog(ev[5]), .mc_hw_error(ev[6]),
    .mc_global_reset(ev[7]), .processor_power_good_stuck(ev[8]), .pm_watchdog(ev[9]), .reset_ack(reset_ack),
    .wake_event(ev[11]), .reset_seq_done(reset_seq_done), .pwrbtn_override(pbo), .global_reset_bit(glb),
    .power_cycle_bit(pcb), .sleep_state(slp), .deep_sleep_enable(ds_en), .deep_sleep_ready(ds_ok),
    .platform_reset_out_n(platform_reset_out_n), .reset_warn(reset_warn), .power_cycle(power_cycle),
    .global_reset(global_reset), .s5_entry(s5_entry), .deep_sleep_state(deep_sleep_state), .host_hold(host_hold),
    .ack_timeout(ack_timeout), .entry_timeout(entry_timeout), .outcome(outcome));
  prc_cpu_model u_cpu (.clk(clk), .resetn(resetn), .reset_warn(reset_warn),
    .platform_reset_out_n(platform_reset_out_n), .ack_en(ack_en), .done_en(done_en),
    .reset_ack(reset_ack), .reset_seq_done(reset_seq_done));

  // ==========================================================
  // Helpers
  // ==========================================================
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Pins held six cycles so the input filter sees them
  task automatic fire(input int m);
    @(posedge clk);
    ev <= 13'(m);
    repeat (6) @(posedge clk);
    ev <= 13'h0;
  endtask
  task automatic wait_oc(input logic [2:0] e, input int lim);
    for (int k = 0; k < lim && outcome !== e; k++) @(negedge clk);
  endtask
  task automatic go(input int m, input logic [2:0] e);
    fire(m);
    // Outputs launched five edges after the pins are set are settled by the negedge
    @(negedge clk);
    wait_oc(e, 20);
  endtask
  task automatic to_idle();
    if (s5_entry === 1'b1 || host_hold === 1'b1) fire(1 << PRC_I_WAKE);
    wait_oc(3'h0, 400);
    chk("idle", outcome, 3'h0);
  endtask
  task automatic set_lv(input logic g, input logic p, input logic s);
    @(posedge clk);
    glb <= g;
    pcb <= p;
    slp <= s;
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_shutdown();
    logic [2:0] e [3] = '{3'h3, 3'h2, 3'h1};
    for (int i = 0; i < 3; i++) begin
      set_lv(i == 0, i != 2, 1'b0);
      go(1 << PRC_I_CPU_SHUT, e[i]);
      chk("shut_kind", outcome, e[i]);
      chk("shut_warn", reset_warn, i != 0);
      to_idle();
    end
    set_lv(1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_mc();
    int         m [4] = '{1 << PRC_I_MC_HR, 1 << PRC_I_MC_HR_PC, 1 << PRC_I_MC_GLOBAL, 1 << PRC_I_PWRGD_STUCK};
    logic [2:0] e [4] = '{3'h1, 3'h2, 3'h3, 3'h3};
    for (int i = 0; i < 4; i++) begin
      go(m[i], e[i]);
      chk("mc_kind", outcome, e[i]);
      chk("mc_warn", reset_warn, e[i] != 3'h3);
      to_idle();
    end
  endtask
  task automatic t_s5();
    int m [4] = '{1 << PRC_I_MC_PBO, 1 << PRC_I_MC_WDT, 1 << PRC_I_MC_HWERR, 1 << PRC_I_PM_WDT};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      ds_en <= 1'b1;
      ds_ok <= i[0];
      go(m[i], 3'h4);
      chk("s5_flag", s5_entry, 1'b1);
      chk("s5_rst", platform_reset_out_n, 1'b0);
      repeat (8) @(negedge clk);
      chk("deep_sleep", deep_sleep_state, i[0]);
      to_idle();
    end
  endtask
  task automatic t_long_press();
    @(posedge clk);
    pbo <= 1'b1;
    repeat (PBO / 2) @(negedge clk);
    chk("press_early", outcome, 3'h0);
    wait_oc(3'h4, PBO + 20);
    chk("press_s5", s5_entry, 1'b1);
    @(posedge clk);
    pbo <= 1'b0;
    to_idle();
  endtask
  task automatic t_sleep();
    set_lv(1'b0, 1'b0, 1'b1);
    fire(1 << PRC_I_MC_HR);
    repeat (10) @(negedge clk);
    chk("sleep_drop", outcome, 3'h0);
    go(1 << PRC_I_MC_HR_PC, 3'h2);
    chk("sleep_nowarn", reset_warn, 1'b0);
    chk("sleep_pc", power_cycle, 1'b1);
    set_lv(1'b0, 1'b0, 1'b0);
    to_idle();
  endtask
  task automatic t_priority();
    go((1 << PRC_I_MC_HR) | (1 << PRC_I_MC_GLOBAL), 3'h3);
    chk("prio_glob", outcome, 3'h3);
    to_idle();
    go((1 << PRC_I_MC_GLOBAL) | (1 << PRC_I_PM_WDT), 3'h4);
    chk("prio_s5", outcome, 3'h4);
    to_idle();
  endtask
  task automatic t_no_ack();
    ack_en = 1'b0;
    go(1 << PRC_I_MC_HR, 3'h1);
    // One negedge of the warning has already passed when go returns
    for (n = 1; n < ACK + 20 && reset_warn === 1'b1; n++) @(negedge clk);
    chk("warn_len", n, ACK);
    chk("ack_tmo", ack_timeout, 1'b1);
    chk("ack_glob", global_reset, 1'b1);
    ack_en = 1'b1;
    to_idle();
  endtask
  task automatic t_entry_tmo();
    done_en = 1'b0;
    go(1 << PRC_I_MC_HR, 3'h1);
    for (n = 0; n < 60 && platform_reset_out_n !== 1'b0; n++) @(negedge clk);
    for (n = 0; n < ENT + 20 && entry_timeout !== 1'b1; n++) @(negedge clk);
    chk("entry_when", n, ENT);
    chk("entry_glob", global_reset, 1'b1);
    done_en = 1'b1;
    to_idle();
  endtask
  task automatic t_power_down();
    go(1 << PRC_I_MC_HR_PD, 3'h2);
    chk("pd_warn", reset_warn, 1'b1);
    for (n = 0; n < 80 && host_hold !== 1'b1; n++) @(negedge clk);
    repeat (10) @(negedge clk);
    chk("pd_hold", host_hold, 1'b1);
    chk("pd_rst", platform_reset_out_n, 1'b0);
    to_idle();
  endtask

  initial begin
    {clk, resetn, pbo, glb, pcb, slp, ds_en, ds_ok, ev} = '0;
    {ack_en, done_en} = 2'h3;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (10) @(negedge clk);
    chk("rst_idle", platform_reset_out_n, 1'b1);
    t_shutdown();
    t_mc();
    t_s5();
    t_long_press();
    t_sleep();
    t_priority();
    t_no_ack();
    t_entry_tmo();
    t_power_down();
    tally_and_finish();
  end
endmodule // testbench
